// File: cci_pkg.sv
// Purpose: shared constants and types for the config crc and irq unit
// Assumes: one clock, register link of single-word requests with one-cycle answer
// Notes:   all addresses are word indices on the register link
package cci_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // register link map
    localparam logic [3:0] ADDR_CRC_RESULT   = 4'h0;
    localparam logic [3:0] ADDR_INTERRUPT_OUT_0_MASK    = 4'h1;
    localparam logic [3:0] ADDR_INTERRUPT_OUT_1_MASK    = 4'h2;
    localparam logic [3:0] ADDR_INTERRUPT_OUT_0_FLAGS   = 4'h3;
    localparam logic [3:0] ADDR_INTERRUPT_OUT_1_FLAGS   = 4'h4;
    localparam logic [3:0] ADDR_DETAIL_BASE  = 4'h5;
    localparam logic [3:0] ADDR_NOLOAD_DET   = 4'h5;
    localparam logic [3:0] ADDR_PHEVENT_DET  = 4'h6;
    localparam logic [3:0] ADDR_CURRENT_PEAK_DETAIL_DET    = 4'h7;
    localparam logic [3:0] ADDR_VOLTAGE_PEAK_DETAIL_DET    = 4'h8;
    localparam logic [3:0] ADDR_SIGN_DET     = 4'h9;
    localparam logic [3:0] ADDR_CRC_STEP48   = 4'ha;

    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;

    // crc engine
    localparam logic [31:0] CRC_POLY     = 32'h04c1_1db7;
    localparam logic [31:0] CRC_INIT     = 32'hffff_ffff;
    localparam logic [11:0] CRC_STEPS    = 12'h928;
    localparam logic [11:0] CRC_TAP_STEP = 12'h030;
    localparam int unsigned IMAGE_BITS   = 2280;
    localparam int unsigned CRC_SRC_BITS = 2344;

    // flag positions and groups
    localparam int unsigned BIT_RESET_DONE = 15;
    localparam int unsigned BIT_CRC_CHANGE = 25;
    localparam logic [31:0] GRP_NOLOAD     = 32'h0000_0007;
    localparam logic [31:0] GRP_PHEVENT    = 32'h0007_0000;
    localparam logic [31:0] GRP_CURRENT_PEAK_DETAIL      = 32'h0080_0000;
    localparam logic [31:0] GRP_VOLTAGE_PEAK_DETAIL      = 32'h0100_0000;
    localparam logic [31:0] GRP_SIGN       = 32'h0004_3fc0;

    typedef enum logic [2:0] {
        CCI_H_IDLE,
        CCI_H_RD_FLAGS,
        CCI_H_RD_DETAIL,
        CCI_H_WR_FLAGS,
        CCI_H_USER
    } cci_host_state_t;
endpackage

// File: cci_if.sv
// Purpose: register link and interrupt pins between device and host
// Assumes: both ends on the same clock
// Notes:   req is a one-cycle pulse, ack answers it one cycle later
`timescale 1ns/10ps
interface cci_if (
    input wire logic clk
);
    logic        req;
    logic        we;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;
    logic        interrupt_out_0_n;
    logic        interrupt_out_1_n;

    modport dev (
        input  clk,
        input  req,
        input  we,
        input  addr,
        input  wdata,
        output ack,
        output rdata,
        output interrupt_out_0_n,
        output interrupt_out_1_n
    );

    modport host (
        input  clk,
        output req,
        output we,
        output addr,
        output wdata,
        input  ack,
        input  rdata,
        input  interrupt_out_0_n,
        input  interrupt_out_1_n
    );
endinterface

// File: cci_device.sv
// Purpose: configuration crc monitor and two-pin interrupt unit
// Assumes: register link per cci_if, events arrive as one-cycle pulses
// Notes:   crc runs continuously, one source bit per clock
// Contract
// - lfsr uses ieee 802.3 polynomial taps
// - lfsr preset to all ones each pass
// - feed lsb first, image then masks, interrupt_out_0_enable_mask last
// - feedback is data xor bit 31
// - 2344 steps, final state into result
// - state at step 48 kept as reference
// - source covers config image and both masks
// - result change sets interrupt_out_1 flag bit 25
// - host raises reset_request on crc change
// - two pins, each with mask and flags
// - flags set regardless of mask
// - pin low while any enabled flag set
// - flag cleared only by writing one
// - masks reset to zero
// - reset done flag unmaskable on interrupt_out_1
// - host writes bit 15 to release
// - interrupt_out_1 bits 0-2 pair with noload detail
// - interrupt_out_1 bits 16-18 pair with phase detail
// - interrupt_out_1 bits 23,24 pair with peak details
// - interrupt_out_0 reversal bits pair with sign detail
// - host reads companion before writing flags
// - host treats pins as active-low levels, polled on each return to idle
`timescale 1ns/10ps
module cci_device (
    input  wire logic                             clk,
    input  wire logic                             rst,
    cci_if.dev                                    link,
    input  wire logic [cci_pkg::IMAGE_BITS-1:0]   config_image,
    input  wire logic [31:0]                      interrupt_out_0_events,
    input  wire logic [31:0]                      interrupt_out_1_events,
    input  wire logic [31:0]                      phase_noload_detail,
    input  wire logic [31:0]                      phase_event_detail,
    input  wire logic [31:0]                      current_peak_detail,
    input  wire logic [31:0]                      voltage_peak_detail,
    input  wire logic [31:0]                      phase_sign_detail,
    output logic      [31:0]                      config_crc_value,
    output logic                                  crc_pass_done
);
    logic [31:0] interrupt_out_0_enable_mask_q;
    logic [31:0] interrupt_out_1_enable_mask_q;
    logic [31:0] interrupt_out_0_event_flags_q;
    logic [31:0] interrupt_out_1_event_flags_q;
    logic [31:0] config_crc_result_q;
    logic [31:0] crc_step48_q;
    logic [31:0] lfsr_q;
    logic [11:0] step_q;
    logic        crc_valid_q;
    logic        reset_pending_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        interrupt_out_0_n_q;
    logic        interrupt_out_1_n_q;
    logic        done_q;

    function automatic logic [31:0] crc_step(input logic [31:0] s, input logic d);
        logic fb;
        fb       = d ^ s[31];
        crc_step = {s[30:0], 1'b0} ^ ({32{fb}} & cci_pkg::CRC_POLY);
    endfunction

    // source order: image bit 0 enters first, interrupt_out_0_enable_mask msb enters last
    wire logic [cci_pkg::CRC_SRC_BITS-1:0] crc_src =
        {interrupt_out_0_enable_mask_q, interrupt_out_1_enable_mask_q, config_image};
    wire logic        crc_bit   = crc_src[step_q];
    wire logic        pass_end  = (step_q == cci_pkg::CRC_STEPS);
    wire logic        crc_moved = pass_end && crc_valid_q && (lfsr_q != config_crc_result_q);

    wire logic        wr        = link.req && link.we;
    wire logic        wr_interrupt_out_0_enable_mask  = wr && (link.addr == cci_pkg::ADDR_INTERRUPT_OUT_0_MASK);
    wire logic        wr_interrupt_out_1_enable_mask  = wr && (link.addr == cci_pkg::ADDR_INTERRUPT_OUT_1_MASK);
    wire logic        wr_flags0 = wr && (link.addr == cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS);
    wire logic        wr_flags1 = wr && (link.addr == cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS);

    // only ones in the written word clear; zeros leave flags alone
    wire logic [31:0] clr0 = wr_flags0 ? link.wdata : 32'h0000_0000;
    wire logic [31:0] clr1 = wr_flags1 ? link.wdata : 32'h0000_0000;

    // events land whatever the mask says; internal events join on interrupt_out_1
    wire logic [31:0] set0 = interrupt_out_0_events;
    wire logic [31:0] set1 = interrupt_out_1_events
        | ({31'h0000_0000, crc_moved} << cci_pkg::BIT_CRC_CHANGE)
        | ({31'h0000_0000, reset_pending_q} << cci_pkg::BIT_RESET_DONE);

    // a set in the clearing cycle wins, so no event is lost
    wire logic [31:0] flags0_d = (interrupt_out_0_event_flags_q & ~clr0) | set0;
    wire logic [31:0] flags1_d = (interrupt_out_1_event_flags_q & ~clr1) | set1;

    // reset done bypasses its mask bit
    wire logic [31:0] unmasked1 = 32'h0000_0001 << cci_pkg::BIT_RESET_DONE;
    wire logic        interrupt_out_0_act  = |(interrupt_out_0_event_flags_q & interrupt_out_0_enable_mask_q);
    wire logic        interrupt_out_1_act  = |(interrupt_out_1_event_flags_q & (interrupt_out_1_enable_mask_q | unmasked1));

    logic [31:0] rd_mux;
    always_comb begin
        case (link.addr)
            cci_pkg::ADDR_CRC_RESULT:  rd_mux = config_crc_result_q;
            cci_pkg::ADDR_INTERRUPT_OUT_0_MASK:   rd_mux = interrupt_out_0_enable_mask_q;
            cci_pkg::ADDR_INTERRUPT_OUT_1_MASK:   rd_mux = interrupt_out_1_enable_mask_q;
            cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS:  rd_mux = interrupt_out_0_event_flags_q;
            cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS:  rd_mux = interrupt_out_1_event_flags_q;
            cci_pkg::ADDR_NOLOAD_DET:  rd_mux = phase_noload_detail;
            cci_pkg::ADDR_PHEVENT_DET: rd_mux = phase_event_detail;
            cci_pkg::ADDR_CURRENT_PEAK_DETAIL_DET:   rd_mux = current_peak_detail;
            cci_pkg::ADDR_VOLTAGE_PEAK_DETAIL_DET:   rd_mux = voltage_peak_detail;
            cci_pkg::ADDR_SIGN_DET:    rd_mux = phase_sign_detail;
            cci_pkg::ADDR_CRC_STEP48:  rd_mux = crc_step48_q;
            default:                   rd_mux = 32'h0000_0000;
        endcase
    end

    // crc engine, restarts from all ones after each pass
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lfsr_q              <= cci_pkg::CRC_INIT;
            step_q              <= 12'h000;
            config_crc_result_q <= 32'h0000_0000;
            crc_step48_q        <= 32'h0000_0000;
            crc_valid_q         <= 1'b0;
            done_q              <= 1'b0;
        end else begin
            done_q <= pass_end;
            if (pass_end) begin
                config_crc_result_q <= lfsr_q;
                crc_valid_q         <= 1'b1;
                lfsr_q              <= cci_pkg::CRC_INIT;
                step_q              <= 12'h000;
            end else begin
                lfsr_q <= crc_step(lfsr_q, crc_bit);
                step_q <= step_q + 12'h001;
            end
            if (step_q == cci_pkg::CRC_TAP_STEP) begin
                crc_step48_q <= lfsr_q;
            end
        end
    end

    // masks and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_out_0_enable_mask_q <= cci_pkg::MASK_RESET;
            interrupt_out_1_enable_mask_q <= cci_pkg::MASK_RESET;
            interrupt_out_0_event_flags_q <= cci_pkg::FLAGS_RESET;
            interrupt_out_1_event_flags_q <= cci_pkg::FLAGS_RESET;
            reset_pending_q    <= 1'b1;
        end else begin
            if (wr_interrupt_out_0_enable_mask) begin
                interrupt_out_0_enable_mask_q <= link.wdata;
            end
            if (wr_interrupt_out_1_enable_mask) begin
                interrupt_out_1_enable_mask_q <= link.wdata;
            end
            interrupt_out_0_event_flags_q <= flags0_d;
            interrupt_out_1_event_flags_q <= flags1_d;
            reset_pending_q    <= 1'b0;
        end
    end

    // answer and pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            interrupt_out_0_n_q <= 1'b1;
            interrupt_out_1_n_q <= 1'b1;
        end else begin
            ack_q    <= link.req;
            rdata_q  <= (link.req && !link.we) ? rd_mux : 32'h0000_0000;
            interrupt_out_0_n_q <= ~interrupt_out_0_act;
            interrupt_out_1_n_q <= ~interrupt_out_1_act;
        end
    end

    assign link.ack         = ack_q;
    assign link.rdata       = rdata_q;
    assign link.interrupt_out_0_n      = interrupt_out_0_n_q;
    assign link.interrupt_out_1_n      = interrupt_out_1_n_q;
    assign config_crc_value = config_crc_result_q;
    assign crc_pass_done    = done_q;
endmodule

// File: cci_host.sv
// Purpose: host end that services both interrupt pins and relays user accesses
// Assumes: device answers each request with ack one cycle later
// Notes:   interrupt service takes priority over user commands
`timescale 1ns/10ps
module cci_host (
    input  wire logic        clk,
    input  wire logic        rst,
    cci_if.host              link,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_we,
    input  wire logic [3:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             cmd_done,
    output logic [31:0]      cmd_rdata,
    output logic             svc_done,
    output logic             svc_line,
    output logic [31:0]      svc_flags,
    output logic             detail_valid,
    output logic [3:0]       detail_addr,
    output logic [31:0]      detail_data,
    output logic             reset_request
);
    cci_pkg::cci_host_state_t state_q;
    logic                     busy_q;
    logic                     line_q;
    logic [31:0]              flags_q;
    logic [3:0]               det_addr_q;
    logic                     req_q;
    logic                     we_q;
    logic [3:0]               addr_q;
    logic [31:0]              wdata_q;
    logic                     cmd_done_q;
    logic [31:0]              cmd_rdata_q;
    logic                     svc_done_q;
    logic                     det_valid_q;
    logic [31:0]              det_data_q;
    logic                     reset_req_q;

    // companion register of the first paired flag; zero means none to read
    function automatic logic [3:0] detail_of(input logic line, input logic [31:0] f);
        detail_of = 4'h0;
        if (!line && |(f & cci_pkg::GRP_SIGN)) detail_of = cci_pkg::ADDR_SIGN_DET;
        else if (line && |(f & cci_pkg::GRP_NOLOAD)) detail_of = cci_pkg::ADDR_NOLOAD_DET;
        else if (line && |(f & cci_pkg::GRP_PHEVENT)) detail_of = cci_pkg::ADDR_PHEVENT_DET;
        else if (line && |(f & cci_pkg::GRP_CURRENT_PEAK_DETAIL)) detail_of = cci_pkg::ADDR_CURRENT_PEAK_DETAIL_DET;
        else if (line && |(f & cci_pkg::GRP_VOLTAGE_PEAK_DETAIL)) detail_of = cci_pkg::ADDR_VOLTAGE_PEAK_DETAIL_DET;
    endfunction

    // pins are looked at again on every return to idle, so events during service stay
    wire logic        pend1      = !link.interrupt_out_1_n;
    wire logic        pend0      = !link.interrupt_out_0_n;
    wire logic        in_idle    = (state_q == cci_pkg::CCI_H_IDLE);
    wire logic [3:0]  det_next   = detail_of(line_q, link.rdata);
    wire logic [3:0]  flags_addr = line_q ? cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS : cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS;
    wire logic        svc_wr     = (state_q == cci_pkg::CCI_H_WR_FLAGS);
    wire logic [3:0]  svc_addr   = (state_q == cci_pkg::CCI_H_RD_DETAIL) ? det_addr_q : flags_addr;

    assign cmd_ready = in_idle && !busy_q && !pend0 && !pend1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= cci_pkg::CCI_H_IDLE;
            busy_q      <= 1'b0;
            line_q      <= 1'b0;
            flags_q     <= 32'h0000_0000;
            det_addr_q  <= 4'h0;
            req_q       <= 1'b0;
            we_q        <= 1'b0;
            addr_q      <= 4'h0;
            wdata_q     <= 32'h0000_0000;
            cmd_done_q  <= 1'b0;
            cmd_rdata_q <= 32'h0000_0000;
            svc_done_q  <= 1'b0;
            det_valid_q <= 1'b0;
            det_data_q  <= 32'h0000_0000;
            reset_req_q <= 1'b0;
        end else begin
            req_q       <= 1'b0;
            cmd_done_q  <= 1'b0;
            svc_done_q  <= 1'b0;
            det_valid_q <= 1'b0;
            if (busy_q) begin
                if (link.ack) begin
                    busy_q <= 1'b0;
                    case (state_q)
                        cci_pkg::CCI_H_RD_FLAGS: begin
                            flags_q    <= link.rdata;
                            det_addr_q <= det_next;
                            // companion is read before the write-back
                            state_q    <= (det_next != 4'h0) ? cci_pkg::CCI_H_RD_DETAIL
                                                             : cci_pkg::CCI_H_WR_FLAGS;
                        end
                        cci_pkg::CCI_H_RD_DETAIL: begin
                            det_valid_q <= 1'b1;
                            det_data_q  <= link.rdata;
                            state_q     <= cci_pkg::CCI_H_WR_FLAGS;
                        end
                        cci_pkg::CCI_H_WR_FLAGS: begin
                            svc_done_q  <= 1'b1;
                            reset_req_q <= flags_q[cci_pkg::BIT_CRC_CHANGE];
                            state_q     <= cci_pkg::CCI_H_IDLE;
                        end
                        cci_pkg::CCI_H_USER: begin
                            cmd_done_q  <= 1'b1;
                            cmd_rdata_q <= link.rdata;
                            state_q     <= cci_pkg::CCI_H_IDLE;
                        end
                        default: begin
                            state_q <= cci_pkg::CCI_H_IDLE;
                        end
                    endcase
                end
            end else if (in_idle) begin
                if (pend1 || pend0) begin
                    line_q  <= pend1;
                    state_q <= cci_pkg::CCI_H_RD_FLAGS;
                end else if (cmd_valid) begin
                    we_q    <= cmd_we;
                    addr_q  <= cmd_addr;
                    wdata_q <= cmd_wdata;
                    state_q <= cci_pkg::CCI_H_USER;
                end
            end else begin
                // one-cycle request, next one no sooner than the cycle after ack
                req_q  <= 1'b1;
                busy_q <= 1'b1;
                if (state_q != cci_pkg::CCI_H_USER) begin
                    we_q    <= svc_wr;
                    addr_q  <= svc_addr;
                    wdata_q <= flags_q;
                end
            end
        end
    end

    assign link.req      = req_q;
    assign link.we       = we_q;
    assign link.addr     = addr_q;
    assign link.wdata    = wdata_q;
    assign cmd_done      = cmd_done_q;
    assign cmd_rdata     = cmd_rdata_q;
    assign svc_done      = svc_done_q;
    assign svc_line      = line_q;
    assign svc_flags     = flags_q;
    assign detail_valid  = det_valid_q;
    assign detail_addr   = det_addr_q;
    assign detail_data   = det_data_q;
    assign reset_request = reset_req_q;
endmodule

// File: cci_link_properties.sv
// Purpose: pin and link properties of the config crc and irq unit
// Assumes: req pulses one cycle, ack follows one cycle later
// Notes:   sees only the cci_if signals
`timescale 1ns/10ps
module cci_link_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req,
    input wire logic        we,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic [31:0] rdata,
    input wire logic        interrupt_out_0_n,
    input wire logic        interrupt_out_1_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mask writes may also release a pin, so they count as a cause
    wire wr0 = req && we && (addr == cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS || addr == cci_pkg::ADDR_INTERRUPT_OUT_0_MASK);
    wire wr1 = req && we && (addr == cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS || addr == cci_pkg::ADDR_INTERRUPT_OUT_1_MASK);
    wire rd  = req && !we;
    property p_ack_next; req |=> ack; endproperty
    property p_ack_cause; ack |-> $past(req); endproperty
    property p_req_pulse; req |=> !req; endproperty
    property p_rst_interrupt_out_1; $fell(rst) |-> ##[0:8] !interrupt_out_1_n; endproperty
    property p_interrupt_out_0_idle; $fell(rst) |-> interrupt_out_0_n [*4]; endproperty
    property p_rd_keeps; rd |=> !$rose(interrupt_out_0_n) && !$rose(interrupt_out_1_n); endproperty
    property p_rel0; $rose(interrupt_out_0_n) |-> $past(wr0) || $past(wr0, 2) || $past(wr0, 3); endproperty
    property p_rel1; $rose(interrupt_out_1_n) |-> $past(wr1) || $past(wr1, 2) || $past(wr1, 3); endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_req_pulse: assert property (p_req_pulse) else $error("request held too long");
    a_rst_interrupt_out_1: assert property (p_rst_interrupt_out_1) else $error("interrupt_out_1 not low after reset");
    a_interrupt_out_0_idle: assert property (p_interrupt_out_0_idle) else $error("interrupt_out_0 low after reset");
    a_rd_keeps: assert property (p_rd_keeps) else $error("read released a pin");
    a_rel0: assert property (p_rel0) else $error("interrupt_out_0 released without write");
    a_rel1: assert property (p_rel1) else $error("interrupt_out_1 released without write");
    c_wr_flags: cover property (wr0 ##1 ack);
    c_interrupt_out_1_low: cover property ($fell(interrupt_out_1_n));
    c_interrupt_out_0_serv: cover property ($fell(interrupt_out_0_n) ##[1:50] $rose(interrupt_out_0_n));
endmodule

// File: config_crc_and_irq_unit_bench.sv
// Purpose: self-checking bench of device and host ends
// Assumes: host relays cmd requests, services pins by itself
// Notes:   each crc check waits for two pass ends, so at least one full pass
`timescale 1ns/10ps
module config_crc_and_irq_unit_bench;
    logic          clk = 0, rst = 1, cv = 0, cw = 0;
    logic [3:0]    ca = '0;
    logic [31:0]   cd = '0, ev0 = '0, ev1 = '0, r, sf_q, m0v, m1v;
    logic [31:0]   det [5:9], seen [5:9];
    logic [2279:0] img = '0;
    logic          sl_q, cmd_ready, cmd_done, svc_done, svc_line, detail_valid, pd;
    logic [31:0]   cmd_rdata, svc_flags, detail_data, crc;
    logic [3:0]    detail_addr;
    integer        seed = 32'h75fa;
    int            n_errors = 0, n_checks = 0, n_svc = 0, gb[5] = '{0, 16, 23, 24, 6};
    always #4 clk = ~clk;
    cci_if cci_if_i (.clk(clk));
    cci_device cci_device_i (.clk(clk), .rst(rst), .link(cci_if_i), .config_image(img),
        .interrupt_out_0_events(ev0), .interrupt_out_1_events(ev1), .phase_noload_detail(det[5]),
        .phase_event_detail(det[6]), .current_peak_detail(det[7]),
        .voltage_peak_detail(det[8]), .phase_sign_detail(det[9]),
        .config_crc_value(crc), .crc_pass_done(pd));
    cci_host cci_host_i (.clk(clk), .rst(rst), .link(cci_if_i), .cmd_valid(cv), .cmd_we(cw),
        .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .cmd_rdata(cmd_rdata), .svc_done(svc_done), .svc_line(svc_line),
        .svc_flags(svc_flags), .detail_valid(detail_valid), .detail_addr(detail_addr),
        .detail_data(detail_data), .reset_request());
    cci_link_properties cci_link_properties_i (.clk(clk), .rst(rst), .req(cci_if_i.req),
        .we(cci_if_i.we), .addr(cci_if_i.addr), .wdata(cci_if_i.wdata), .ack(cci_if_i.ack),
        .rdata(cci_if_i.rdata), .interrupt_out_0_n(cci_if_i.interrupt_out_0_n), .interrupt_out_1_n(cci_if_i.interrupt_out_1_n));
    always @(posedge clk) begin
        if (svc_done === 1'b1) begin
            sl_q <= svc_line;
            sf_q <= svc_flags;
            n_svc <= n_svc + 1;
        end
        if (detail_valid === 1'b1) seen[detail_addr] <= detail_data;
    end
    function automatic logic [31:0] crc_model(input int n);
        logic [31:0] s;
        logic        b;
        s = 32'hffff_ffff;
        for (int j = 0; j < n; j++) begin
            b = j < 2280 ? img[j] : j < 2312 ? m1v[j-2280] : m0v[j-2312];
            s = {s[30:0], 1'b0} ^ ({32{b ^ s[31]}} & 32'h04c1_1db7);
        end
        return s;
    endfunction
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_checks++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic cmd(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        cv <= 1;
        cw <= w;
        ca <= a;
        cd <= d;
        @(posedge clk);
        for (k = 0; k < 200 && cmd_ready !== 1'b1; k++) @(posedge clk);
        cv <= 0;
        for (k = 0; k < 200 && cmd_done !== 1'b1; k++) @(posedge clk);
        if (k == 200) n_errors++;
        r = cmd_rdata;
    endtask
    task automatic wsvc(input int k0);
        for (int k = 0; k < 300 && n_svc == k0; k++) @(posedge clk);
        if (n_svc == k0) n_errors++;
    endtask
    // two pass ends, so the second pass saw only settled sources
    task automatic wpass;
        int k;
        repeat (2) begin
            for (k = 0; k < 3000 && pd !== 1'b1; k++) @(posedge clk);
            if (k == 3000) n_errors++;
            @(posedge clk);
        end
    endtask
    task automatic do_rst;
        int k0;
        k0 = n_svc;
        rst <= 1;
        repeat (5) @(posedge clk);
        rst <= 0;
        wsvc(k0);
        check({31'h0, sl_q}, 32'h1);
        check(sf_q & 32'h0000_8000, 32'h0000_8000);
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_0_MASK, '0);
        check(r, 32'h0);
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_1_MASK, '0);
        check(r, 32'h0);
        $display("reset test done");
    endtask
    task automatic crc_test;
        wpass;
        check(crc, crc_model(2344));
        cmd(0, cci_pkg::ADDR_CRC_RESULT, '0);
        check(r, crc_model(2344));
        cmd(0, cci_pkg::ADDR_CRC_STEP48, '0);
        check(r, crc_model(48));
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS, '0);
        check(r & 32'h0200_0000, 32'h0200_0000);
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_1_FLAGS, 32'h0200_0000);
        $display("crc test done");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        results;
    end
    initial begin
        int k0;
        for (int i = 0; i < 2280; i++) img[i] = $random(seed);
        foreach (det[a]) det[a] = $random(seed);
        do_rst;
        m0v = 32'h0000_0000;
        m1v = 32'h0000_0000;
        wpass;
        m0v = 32'h0000_0040;
        m1v = 32'h0181_0001;
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_0_MASK, m0v);
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_1_MASK, m1v);
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_1_MASK, '0);
        check(r, m1v);
        crc_test;
        for (int i = 0; i < 5; i++) begin
            k0 = n_svc;
            if (i < 4) ev1[gb[i]] <= 1'b1;
            else ev0[gb[i]] <= 1'b1;
            @(posedge clk);
            ev0 <= '0;
            ev1 <= '0;
            wsvc(k0);
            check({31'h0, sl_q}, {31'h0, i < 4});
            check(sf_q, 32'h1 << gb[i]);
            check(seen[5+i], det[5+i]);
        end
        $display("detail test done");
        ev0[3] <= 1'b1;
        @(posedge clk);
        ev0 <= '0;
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS, '0);
        check(r, 32'h8);
        check({31'h0, cci_if_i.interrupt_out_0_n}, 32'h1);
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS, '0);
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS, '0);
        check(r, 32'h8);
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS, 32'h8);
        cmd(0, cci_pkg::ADDR_INTERRUPT_OUT_0_FLAGS, '0);
        check(r, 32'h0);
        $display("masked test done");
        for (int i = 0; i < 2280; i++) img[i] <= $random(seed);
        m0v = $random(seed);
        cmd(1, cci_pkg::ADDR_INTERRUPT_OUT_0_MASK, m0v);
        crc_test;
        do_rst;
        results;
    end
endmodule
